/* include/nvw_pkg.sv */
`default_nettype none
// ****************************************************************
// Shared constants and carriers
// ****************************************************************
package nvw_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [15:0] OFF_CONTROL = 16'h0760;
    localparam logic [15:0] OFF_ADDR_LOW = 16'h0762;
    localparam logic [15:0] OFF_ADDR_HIGH = 16'h0764;
    localparam logic [15:0] OFF_UNLOCK_KEY = 16'h0766;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTL_START_BIT = 15;
    localparam int CTL_ARM_BIT = 14;
    localparam int CTL_ERR_BIT = 13;
    localparam int CTL_TSEL_BIT = 8;
    localparam int CTL_OPC_MSB = 6;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
    localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;

    // Operation code: bit 6 erase, bit 2 data EEPROM target, bit 0 block
    localparam int OPC_ERASE_BIT = 6;
    localparam int OPC_EE_BIT = 2;
    localparam int OPC_BLOCK_BIT = 0;

    // ****************************************************************
    // Unlock keys
    // ****************************************************************
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // ****************************************************************
    // Data EEPROM geometry
    // ****************************************************************
    localparam int EE_ADDR_W = 12;
    localparam int EE_WORDS = 4096;
    localparam int BLOCK_W = 4;
    localparam int BLOCK_WORDS = 16;
    localparam logic [11:0] EE_PAGE = 12'h07FF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 40;
    localparam int OP_TIME_NS = 2000000;
    localparam int OP_CYCLES = (OP_TIME_NS * CLK_MHZ) / 1000;

    // ****************************************************************
    // Carriers and states
    // ****************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } nvw_sfr_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [23:0] ea;
        logic [15:0] wdata;
    } nvw_tbl_req_t;

    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} nvw_key_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_TIME, SEQ_COMMIT} nvw_seq_t;

endpackage : nvw_pkg
`default_nettype wire

/* rtl/nvw_eeprom_array.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Data EEPROM storage, one write port and one registered read port
// ****************************************************************
module nvw_eeprom_array
    import nvw_pkg::*;
(
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [11:0] waddr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [11:0] raddr_in,
    output logic [15:0] rdata_out
);

    logic [15:0] mem_q [0:EE_WORDS-1];
    logic [15:0] rdata_q;

    // No reset: contents are the non-volatile image
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
        rdata_q <= mem_q[raddr_in];
    end

    assign rdata_out = rdata_q;

endmodule : nvw_eeprom_array
`default_nettype wire

/* rtl/nvw_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module nvw_ctrl
    import nvw_pkg::*;
#(
    parameter int OP_CYCLES_P = OP_CYCLES
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic power_on_reset_in,
    input wire logic external_master_reset_in,
    input wire logic wdt_reset_in,
    input wire nvw_sfr_req_t sfr_in,
    input wire nvw_tbl_req_t tbl_in,
    input wire logic op_done_clr_in,
    output logic [15:0] sfr_rdata_out,
    output logic [15:0] tbl_rdata_out,
    output logic op_done_flag_out,
    output logic cpu_stall_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    nvw_key_t key_q, key_d;
    nvw_seq_t seq_q, seq_d;
    logic start_q, start_d;
    logic arm_q, arm_d;
    logic err_q, err_d;
    logic tsel_q, tsel_d;
    logic [6:0] opc_q, opc_d;
    logic [6:0] run_op_q, run_op_d;
    logic [23:0] base_q, base_d;
    logic [31:0] cnt_q, cnt_d;
    logic [BLOCK_W-1:0] idx_q, idx_d;
    logic stall_q, stall_d;
    logic done_q, done_d;
    logic [15:0] addr_low_q, addr_low_d;
    logic [7:0] addr_high_q, addr_high_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] latch_q [0:BLOCK_WORDS-1];
    logic [15:0] latch_d [0:BLOCK_WORDS-1];

    logic ctl_wr, key_wr, lo_wr, hi_wr, any_access;
    logic start_req, done_set, run_ee, run_block, run_erase, base_hit;
    logic tbl_hit, mem_we;
    logic [11:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] ctl_word;

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign ctl_wr = sfr_in.wr && (sfr_in.addr == OFF_CONTROL);
    assign key_wr = sfr_in.wr && (sfr_in.addr == OFF_UNLOCK_KEY);
    assign lo_wr = sfr_in.wr && (sfr_in.addr == OFF_ADDR_LOW);
    assign hi_wr = sfr_in.wr && (sfr_in.addr == OFF_ADDR_HIGH);
    assign any_access = sfr_in.wr || sfr_in.rd || tbl_in.valid;
    assign tbl_hit = tbl_in.valid && (tbl_in.ea[23:12] == EE_PAGE);

    // Start needs the open key window and an arm bit stored earlier
    assign start_req = ctl_wr && sfr_in.wdata[CTL_START_BIT] && (key_q == KEY_OPEN)
        && arm_q && !start_q;

    assign run_ee = run_op_q[OPC_EE_BIT];
    assign run_block = run_op_q[OPC_BLOCK_BIT];
    assign run_erase = run_op_q[OPC_ERASE_BIT];
    assign base_hit = (base_q[23:12] == EE_PAGE);

    assign ctl_word = {start_q, arm_q, err_q, 4'h0, tsel_q, 1'b0, opc_q};

    // ****************************************************************
    // Unlock key window
    // ****************************************************************
    always_comb begin
        key_d = key_q;
        case (key_q)
            KEY_IDLE: begin
                if (key_wr && (sfr_in.wdata[7:0] == KEY_FIRST)) begin
                    key_d = KEY_HALF;
                end
            end
            KEY_HALF: begin
                if (key_wr && (sfr_in.wdata[7:0] == KEY_SECOND)) begin
                    key_d = KEY_OPEN;
                end else if (any_access) begin
                    key_d = KEY_IDLE;
                end
            end
            KEY_OPEN: begin
                // Window lasts exactly one following access, whatever it is
                if (any_access) begin
                    key_d = KEY_IDLE;
                end
            end
            default: begin
                key_d = KEY_IDLE;
            end
        endcase
        if (rst_in || power_on_reset_in) begin
            key_d = KEY_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        key_q <= key_d;
    end

    // ****************************************************************
    // Control register and operation sequencer
    // ****************************************************************
    always_comb begin
        seq_d = seq_q;
        start_d = start_q;
        arm_d = arm_q;
        err_d = err_q;
        tsel_d = tsel_q;
        opc_d = opc_q;
        run_op_d = run_op_q;
        base_d = base_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        stall_d = stall_q;
        done_set = 1'b0;
        mem_we = 1'b0;
        mem_waddr = base_q[11:0];
        mem_wdata = ERASED_WORD;

        if (ctl_wr) begin
            // Clearing arm mid-cycle has no effect on the running operation
            arm_d = sfr_in.wdata[CTL_ARM_BIT];
            err_d = err_q & sfr_in.wdata[CTL_ERR_BIT];
            if (!start_q) begin
                tsel_d = sfr_in.wdata[CTL_TSEL_BIT];
                opc_d = sfr_in.wdata[CTL_OPC_MSB:0];
            end
            // A zero in the start bit is simply not looked at
        end

        case (seq_q)
            SEQ_IDLE: begin
                if (start_req) begin
                    start_d = 1'b1;
                    run_op_d = sfr_in.wdata[CTL_OPC_MSB:0];
                    base_d = {addr_high_q, addr_low_q};
                    cnt_d = 32'(OP_CYCLES_P - 1);
                    stall_d = !sfr_in.wdata[OPC_EE_BIT];
                    seq_d = SEQ_TIME;
                end
            end
            SEQ_TIME: begin
                if (cnt_q == 32'h0000_0000) begin
                    idx_d = '0;
                    if (run_ee && base_hit) begin
                        seq_d = SEQ_COMMIT;
                    end else begin
                        // Flash array itself lies outside this block
                        start_d = 1'b0;
                        stall_d = 1'b0;
                        done_set = 1'b1;
                        seq_d = SEQ_IDLE;
                    end
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
            end
            SEQ_COMMIT: begin
                // Array is updated only at the end, so a reset during the timed wait leaves it intact
                mem_we = 1'b1;
                if (run_block) begin
                    mem_waddr = {base_q[11:BLOCK_W], idx_q};
                    mem_wdata = run_erase ? ERASED_WORD : latch_q[idx_q];
                end else begin
                    mem_waddr = base_q[11:0];
                    mem_wdata = run_erase ? ERASED_WORD : latch_q[base_q[BLOCK_W-1:0]];
                end
                if (!run_block || (idx_q == BLOCK_W'(BLOCK_WORDS - 1))) begin
                    start_d = 1'b0;
                    stall_d = 1'b0;
                    done_set = 1'b1;
                    seq_d = SEQ_IDLE;
                end else begin
                    idx_d = idx_q + 1'b1;
                end
            end
            default: begin
                seq_d = SEQ_IDLE;
            end
        endcase

        if (power_on_reset_in) begin
            seq_d = SEQ_IDLE;
            start_d = 1'b0;
            arm_d = 1'b0;
            err_d = 1'b0;
            tsel_d = 1'b0;
            opc_d = CONTROL_RESET[CTL_OPC_MSB:0];
            stall_d = 1'b0;
            cnt_d = 32'h0000_0000;
            idx_d = '0;
            mem_we = 1'b0;
        end else if (rst_in) begin
            // Write interrupted by external master or watchdog reset is flagged so software can redo it
            err_d = err_q | (start_q && (external_master_reset_in || wdt_reset_in));
            seq_d = SEQ_IDLE;
            start_d = 1'b0;
            arm_d = 1'b0;
            tsel_d = 1'b0;
            opc_d = CONTROL_RESET[CTL_OPC_MSB:0];
            stall_d = 1'b0;
            cnt_d = 32'h0000_0000;
            idx_d = '0;
            mem_we = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        seq_q <= seq_d;
        start_q <= start_d;
        arm_q <= arm_d;
        err_q <= err_d;
        tsel_q <= tsel_d;
        opc_q <= opc_d;
        run_op_q <= run_op_d;
        base_q <= base_d;
        cnt_q <= cnt_d;
        idx_q <= idx_d;
        stall_q <= stall_d;
    end

    // ****************************************************************
    // Completion flag: a new completion wins over a same-cycle clear
    // ****************************************************************
    always_comb begin
        done_d = done_set | (done_q & ~op_done_clr_in);
        if (rst_in || power_on_reset_in) begin
            done_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        done_q <= done_d;
    end

    // ****************************************************************
    // Address registers, untouched by system reset
    // ****************************************************************
    always_comb begin
        addr_low_d = addr_low_q;
        addr_high_d = addr_high_q;
        if (lo_wr) begin
            addr_low_d = sfr_in.wdata;
        end
        if (hi_wr) begin
            addr_high_d = sfr_in.wdata[7:0];
        end
        if (tbl_in.valid) begin
            addr_low_d = tbl_in.ea[15:0];
            addr_high_d = tbl_in.ea[23:16];
        end
        if (power_on_reset_in) begin
            addr_low_d = ADDR_LOW_RESET;
            addr_high_d = ADDR_HIGH_RESET;
        end
        // System reset deliberately absent here
    end

    always_ff @(posedge clk_in) begin
        addr_low_q <= addr_low_d;
        addr_high_q <= addr_high_d;
    end

    // ****************************************************************
    // Write latches, loaded by table write low into the page
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < BLOCK_WORDS; gi++) begin : g_latch
            always_comb begin
                latch_d[gi] = latch_q[gi];
                if (tbl_hit && tbl_in.write && (tbl_in.ea[BLOCK_W-1:0] == BLOCK_W'(gi))) begin
                    latch_d[gi] = tbl_in.wdata;
                end
            end
            always_ff @(posedge clk_in) begin
                latch_q[gi] <= latch_d[gi];
            end
        end
    endgenerate

    // ****************************************************************
    // Register readback; key register always reads zero
    // ****************************************************************
    always_comb begin
        rdata_d = 16'h0000;
        if (sfr_in.rd) begin
            case (sfr_in.addr)
                OFF_CONTROL: rdata_d = ctl_word;
                OFF_ADDR_LOW: rdata_d = addr_low_q;
                OFF_ADDR_HIGH: rdata_d = {8'h00, addr_high_q};
                OFF_UNLOCK_KEY: rdata_d = 16'h0000;
                default: rdata_d = 16'h0000;
            endcase
        end
        if (rst_in || power_on_reset_in) begin
            rdata_d = 16'h0000;
        end
    end

    always_ff @(posedge clk_in) begin
        rdata_q <= rdata_d;
    end

    // ****************************************************************
    // Storage; reads are not blocked while a cycle runs
    // ****************************************************************
    nvw_eeprom_array u_array (
        .clk_in(clk_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(tbl_in.ea[11:0]),
        .rdata_out(tbl_rdata_out)
    );

    assign sfr_rdata_out = rdata_q;
    assign op_done_flag_out = done_q;
    assign cpu_stall_out = stall_q;

endmodule : nvw_ctrl
`default_nettype wire

/* tb/nvw_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module nvw_ctrl_assertions
    import nvw_pkg::*;
#(
    parameter int OP_CYCLES_P = OP_CYCLES
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic power_on_reset_in,
    input wire logic external_master_reset_in,
    input wire logic wdt_reset_in,
    input wire nvw_sfr_req_t sfr_in,
    input wire nvw_tbl_req_t tbl_in,
    input wire logic op_done_clr_in,
    input wire logic [15:0] sfr_rdata_out,
    input wire logic [15:0] tbl_rdata_out,
    input wire logic op_done_flag_out,
    input wire logic cpu_stall_out
);
    // Counter instead of a long repetition, so the full time stays cheap to check
    logic [31:0] run_q;
    logic [31:0] run_d;
    always_comb begin
        run_d = cpu_stall_out ? run_q + 32'h0000_0001 : 32'h0000_0000;
    end
    always_ff @(posedge clk_in) begin
        run_q <= run_d;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in || power_on_reset_in);
    chk_key_reads_zero: assert property ($past(sfr_in.rd && sfr_in.addr == OFF_UNLOCK_KEY)
        |-> sfr_rdata_out == 16'h0000) else $error("key register read not zero");
    chk_done_sticky: assert property (op_done_flag_out && !op_done_clr_in |=> op_done_flag_out)
        else $error("done flag dropped without clear");
    chk_stall_flash_only: assert property ($rose(cpu_stall_out) |-> $past(sfr_in.wr
        && sfr_in.addr == OFF_CONTROL && !sfr_in.wdata[OPC_EE_BIT])) else $error("stall on ee op");
    chk_second_key_first: assert property ($rose(cpu_stall_out) |-> $past(sfr_in.wr
        && sfr_in.addr == OFF_UNLOCK_KEY && sfr_in.wdata[7:0] == KEY_SECOND, 2))
        else $error("start without second key");
    chk_key_pair_order: assert property ($rose(cpu_stall_out) |-> $past(sfr_in.wr
        && sfr_in.addr == OFF_UNLOCK_KEY && sfr_in.wdata[7:0] == KEY_FIRST, 3))
        else $error("start without first key");
    chk_stall_min: assert property ($rose(cpu_stall_out) |-> cpu_stall_out [*8])
        else $error("stall too short");
    chk_stall_full_time: assert property ($fell(cpu_stall_out) && !$past(rst_in)
        && !$past(power_on_reset_in) |-> op_done_flag_out && run_q == OP_CYCLES_P)
        else $error("stall length or done wrong");
    chk_start_holds_set: assert property ($past(sfr_in.rd && sfr_in.addr == OFF_CONTROL
        && cpu_stall_out) && cpu_stall_out |-> sfr_rdata_out[CTL_START_BIT])
        else $error("start bit lost while running");
endmodule : nvw_ctrl_assertions
bind nvw_ctrl nvw_ctrl_assertions #(.OP_CYCLES_P(OP_CYCLES_P)) u_chk (.clk_in(clk_in),
    .rst_in(rst_in), .power_on_reset_in(power_on_reset_in),
    .external_master_reset_in(external_master_reset_in), .wdt_reset_in(wdt_reset_in),
    .sfr_in(sfr_in), .tbl_in(tbl_in), .op_done_clr_in(op_done_clr_in),
    .sfr_rdata_out(sfr_rdata_out), .tbl_rdata_out(tbl_rdata_out),
    .op_done_flag_out(op_done_flag_out), .cpu_stall_out(cpu_stall_out));
`default_nettype wire

/* tb/nvw_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nvw_cpu_model
    import nvw_pkg::*;
(
    input wire logic clk_in,
    input wire logic [15:0] sfr_rdata_in,
    output var nvw_sfr_req_t sfr_out,
    output var nvw_tbl_req_t tbl_out
);
    initial begin
        sfr_out = '0;
        tbl_out = '0;
    end
    // One instruction per cycle, held until the sampling edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        sfr_out = '{w, !w, a, d};
        tbl_out.valid = 1'b0;
        @(posedge clk_in);
        #1;
    endtask : acc
    task automatic tbl(input logic w, input logic [23:0] ea, input logic [15:0] d);
        tbl_out = '{1'b1, w, ea, d};
        sfr_out.wr = 1'b0;
        sfr_out.rd = 1'b0;
        @(posedge clk_in);
        #1;
    endtask : tbl
    // Released lines show garbage, not the last value
    task automatic idle();
        sfr_out = '{1'b0, 1'b0, ~sfr_out.addr, ~sfr_out.wdata};
        tbl_out = '{1'b0, ~tbl_out.write, ~tbl_out.ea, ~tbl_out.wdata};
        @(posedge clk_in);
        #1;
    endtask : idle
    task automatic rd(input logic [15:0] a, output logic [15:0] q);
        acc(1'b0, a, 16'h0000);
        q = sfr_rdata_in;
    endtask : rd
    // Keys and start adjacent, as if low-priority interrupts were held off
    task automatic start(input logic [15:0] ctl);
        acc(1'b1, OFF_UNLOCK_KEY, {8'h00, KEY_FIRST});
        acc(1'b1, OFF_UNLOCK_KEY, {8'h00, KEY_SECOND});
        acc(1'b1, OFF_CONTROL, ctl | 16'h8000);
    endtask : start
    task automatic nops();
        idle();
        idle();
    endtask : nops
endmodule : nvw_cpu_model
`default_nettype wire

/* tb/nvw_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t got %h expected %h", $time, (g), (e)); end end
module nvw_ctrl_tb
    import nvw_pkg::*;
;
    localparam int OPN = 20;
    localparam int LIMIT = 3000;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic por = 1'b1;
    logic emr = 1'b0;
    logic wdt = 1'b0;
    logic clr = 1'b0;
    nvw_sfr_req_t sfr;
    nvw_tbl_req_t tbl;
    logic [15:0] sfr_q;
    logic [15:0] tbl_q;
    logic done;
    logic stall;
    logic [15:0] q;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int n = 0;
    always #12.5 clk_in = ~clk_in;
    nvw_ctrl #(.OP_CYCLES_P(OPN)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .power_on_reset_in(por), .external_master_reset_in(emr), .wdt_reset_in(wdt),
        .sfr_in(sfr), .tbl_in(tbl), .op_done_clr_in(clr), .sfr_rdata_out(sfr_q),
        .tbl_rdata_out(tbl_q), .op_done_flag_out(done), .cpu_stall_out(stall));
    nvw_cpu_model cpu (.clk_in(clk_in), .sfr_rdata_in(sfr_q), .sfr_out(sfr), .tbl_out(tbl));
    task automatic rd(input logic [15:0] a);
        cpu.rd(a, q);
        n++;
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        cpu.acc(1'b1, a, d);
        n++;
    endtask : wr
    task automatic trd(input logic [23:0] ea);
        cpu.tbl(1'b0, ea, 16'h0000);
        q = tbl_q;
    endtask : trd
    task automatic launch(input logic [15:0] opc);
        clr = 1'b1;
        cpu.acc(1'b1, OFF_CONTROL, 16'h4000 | opc);
        clr = 1'b0;
        cpu.start(16'h4000 | opc);
        cpu.nops();
        n = 2;
    endtask : launch
    // Software waits for completion before the next operation
    task automatic finish(input int exp_n);
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        `CHK(n, exp_n);
        rd(OFF_CONTROL);
        `CHK(q[CTL_START_BIT], 1'b0);
        `CHK(done, 1'b1);
    endtask : finish
    task automatic t_reset_values();
        rd(OFF_CONTROL);
        `CHK(q, CONTROL_RESET);
        rd(OFF_UNLOCK_KEY);
        `CHK(q, 16'h0000);
        rd(OFF_ADDR_HIGH);
        `CHK(q, 16'h0000);
        rd(16'h0768);
        `CHK(q, 16'h0000);
    endtask : t_reset_values
    task automatic t_refusals();
        wr(OFF_CONTROL, 16'h0004);
        cpu.start(16'h4004);
        rd(OFF_CONTROL);
        `CHK(q[CTL_START_BIT], 1'b0);
        wr(OFF_CONTROL, 16'hC041);
        rd(OFF_CONTROL);
        `CHK(q[CTL_START_BIT], 1'b0);
        wr(OFF_UNLOCK_KEY, 16'h0055);
        trd(24'h00_0000);
        wr(OFF_UNLOCK_KEY, 16'h00AA);
        wr(OFF_CONTROL, 16'hC041);
        `CHK(stall, 1'b0);
    endtask : t_refusals
    task automatic t_flash();
        launch(16'h0041);
        rd(OFF_CONTROL);
        `CHK(q[CTL_START_BIT], 1'b1);
        `CHK(stall, 1'b1);
        finish(OPN);
        `CHK(stall, 1'b0);
    endtask : t_flash
    task automatic t_ee_word();
        wr(OFF_ADDR_LOW, 16'hF003);
        wr(OFF_ADDR_HIGH, 16'h007F);
        launch(16'h0044);
        wr(OFF_CONTROL, 16'h4044);
        rd(OFF_CONTROL);
        `CHK(q[CTL_START_BIT], 1'b1);
        `CHK(stall, 1'b0);
        finish(OPN + 1);
        trd(24'h7F_F003);
        `CHK(q, ERASED_WORD);
        cpu.tbl(1'b1, 24'h7F_F003, 16'hA5C3);
        launch(16'h0004);
        finish(OPN + 1);
        rd(OFF_ADDR_LOW);
        `CHK(q, 16'hF003);
        rd(OFF_ADDR_HIGH);
        `CHK(q, 16'h007F);
        trd(24'h7F_F003);
        `CHK(q, 16'hA5C3);
    endtask : t_ee_word
    task automatic t_ee_block();
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            cpu.tbl(1'b1, 24'h7F_F100 + 24'(i), 16'h5A00 + 16'(i));
        end
        wr(OFF_ADDR_LOW, 16'hF040);
        wr(OFF_ADDR_HIGH, 16'h007F);
        launch(16'h0005);
        finish(OPN + BLOCK_WORDS);
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            trd(24'h7F_F040 + 24'(i));
            `CHK(q, 16'h5A00 + 16'(i));
        end
        launch(16'h0045);
        finish(OPN + BLOCK_WORDS);
        for (int i = 0; i < BLOCK_WORDS; i++) begin
            trd(24'h7F_F040 + 24'(i));
            `CHK(q, ERASED_WORD);
        end
    endtask : t_ee_block
    // Reset while an erase runs, once each for external master reset and watchdog reset
    task automatic t_reset_abort();
        for (int k = 0; k < 2; k++) begin
            wr(OFF_ADDR_LOW, 16'hF050);
            wr(OFF_ADDR_HIGH, 16'h007F);
            launch(16'h0044);
            rst_in = 1'b1;
            emr = (k == 0);
            wdt = (k == 1);
            cpu.idle();
            rst_in = 1'b0;
            emr = 1'b0;
            wdt = 1'b0;
            rd(OFF_CONTROL);
            `CHK(q[CTL_ERR_BIT], 1'b1);
            `CHK(q[CTL_START_BIT], 1'b0);
            rd(OFF_ADDR_LOW);
            `CHK(q, 16'hF050);
        end
        // Error kept set by the write, so power-up must clear it as well as arm
        wr(OFF_CONTROL, 16'h6000);
        por = 1'b1;
        cpu.idle();
        por = 1'b0;
        rd(OFF_CONTROL);
        `CHK(q, CONTROL_RESET);
    endtask : t_reset_abort
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        por = 1'b0;
        t_reset_values();
        t_refusals();
        t_flash();
        t_ee_word();
        t_ee_block();
        t_reset_abort();
        print_verdict();
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            print_verdict();
        end
    end
endmodule : nvw_ctrl_tb
`default_nettype wire
